// file: hdl/cpu_status_flag_register.sv
`timescale 1ns/1ps
module cpu_status_flag_register
   import status_reg_pkg::*;
(
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   input  wire logic [AXI_ADDR_W-1:0]   s_axi_awaddr,
   input  wire logic                    s_axi_awvalid,
   output      logic                    s_axi_awready,
   input  wire logic [AXI_DATA_W-1:0]   s_axi_wdata,
   input  wire logic [AXI_STRB_W-1:0]   s_axi_wstrb,
   input  wire logic                    s_axi_wvalid,
   output      logic                    s_axi_wready,
   output      logic [1:0]              s_axi_bresp,
   output      logic                    s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   input  wire logic [AXI_ADDR_W-1:0]   s_axi_araddr,
   input  wire logic                    s_axi_arvalid,
   output      logic                    s_axi_arready,
   output      logic [AXI_DATA_W-1:0]   s_axi_rdata,
   output      logic [1:0]              s_axi_rresp,
   output      logic                    s_axi_rvalid,
   input  wire logic                    s_axi_rready,
   input  wire logic                    ex_valid,
   input  wire alu_op_t                 ex_op,
   input  wire logic [DATA_W-1:0]       ex_w,
   input  wire logic [DATA_W-1:0]       ex_file,
   input  wire logic                    ex_dest_status,
   input  wire logic [BIT_SEL_W-1:0]    ex_bit,
   input  wire logic                    watchdog_timeout_event,
   input  wire logic                    watchdog_clear_instr,
   input  wire logic                    sleep_instr,
   input  wire logic [FILE_ADDR_W-1:0]  dir_file_addr,
   input  wire logic [DATA_W-1:0]       fsr,
   output      logic [DATA_W-1:0]       ex_result,
   output      logic [DATA_W-1:0]       status_out,
   output      logic                    indirect_bank_sel,
   output      logic                    direct_bank_sel_hi,
   output      logic                    direct_bank_sel_lo,
   output      logic                    watchdog_timeout_flag,
   output      logic                    power_down_flag,
   output      logic                    zero_flag,
   output      logic                    digit_carry_flag,
   output      logic                    carry_flag,
   output      logic [BANK_ADDR_W-1:0]  direct_addr,
   output      logic [BANK_ADDR_W-1:0]  indirect_addr,
   output      logic                    status_selected
);
   logic [DATA_W-1:0]       status;
   logic [DATA_W-1:0]       next_status;
   logic [DATA_W-1:0]       result_reg;
   logic [DATA_W-1:0]       bus_status;
   logic [DATA_W-1:0]       exec_status;
   logic [DATA_W-1:0]       flagged_status;
   logic [DATA_W-1:0]       flag_vec;
   logic [DATA_W-1:0]       result_wmask;
   logic [DATA_W-1:0]       flag_wmask;

   logic                    aw_full;
   logic                    w_full;
   logic [AXI_ADDR_W-1:0]   aw_addr;
   logic [AXI_DATA_W-1:0]   w_data;
   logic [AXI_STRB_W-1:0]   w_strb;
   logic                    wr_fire;
   logic                    wr_hit_status;
   logic                    wr_mapped;
   logic                    aw_take;
   logic                    w_take;
   logic                    ar_take;
   logic [AXI_DATA_W-1:0]   rd_word;
   logic                    rd_mapped;

   alu_if alu_bus ();

   flag_alu u_alu (
      .bus (alu_bus.alu)
   );

   // Write channel: address and data are held independently, then committed together
   assign s_axi_awready = !aw_full && !s_axi_bvalid;
   assign s_axi_wready  = !w_full && !s_axi_bvalid;
   assign aw_take       = s_axi_awvalid && s_axi_awready;
   assign w_take        = s_axi_wvalid && s_axi_wready;
   assign wr_fire       = aw_full && w_full && !s_axi_bvalid;
   assign wr_hit_status = wr_fire && (aw_addr == OFF_STATUS) && w_strb[0];
   assign wr_mapped     = (aw_addr == OFF_STATUS) || (aw_addr == OFF_RESULT)
                        || (aw_addr == OFF_BANK);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full      <= 1'b0;
         w_full       <= 1'b0;
         aw_addr      <= '0;
         w_data       <= '0;
         w_strb       <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_full <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_full <= 1'b0;
         end
         if (w_take) begin
            w_full <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_full <= 1'b0;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read channel: one word per request, answered the cycle after the address
   assign s_axi_arready = !s_axi_rvalid;
   assign ar_take       = s_axi_arvalid && s_axi_arready;
   assign rd_mapped     = (s_axi_araddr == OFF_STATUS) || (s_axi_araddr == OFF_RESULT)
                        || (s_axi_araddr == OFF_BANK);
   assign rd_word = (s_axi_araddr == OFF_STATUS) ? {24'h000000, status} :
                    (s_axi_araddr == OFF_RESULT) ? {24'h000000, result_reg} :
                    (s_axi_araddr == OFF_BANK)   ? {23'h000000, indirect_addr[BANK_ADDR_W-1],
                                                    6'h00, status[BIT_RP1], status[BIT_RP0]} :
                    '0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= RESP_OKAY;
      end else if (ar_take) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // A bus write behaves like a move into status; hardware-only flags are kept
   assign bus_status = wr_hit_status ?
                       ((status & MASK_HW_ONLY) | (w_data[DATA_W-1:0] & ~MASK_HW_ONLY)) :
                       status;

   // The instruction sees status as it stands after a same-cycle bus write
   assign alu_bus.op       = ex_op;
   assign alu_bus.a        = ex_w;
   assign alu_bus.b        = ex_dest_status ? bus_status : ex_file;
   assign alu_bus.carry_in = bus_status[BIT_C];
   assign alu_bus.bit_sel  = ex_bit;

   // Clear-file writes only the bank bits and Z, so the carries survive it
   assign result_wmask = (ex_op == OP_CLR) ? MASK_BANK :
                         ~(MASK_HW_ONLY | alu_bus.affect);
   assign flag_wmask   = ex_valid ? alu_bus.affect : MASK_NONE;

   always_comb begin
      flag_vec        = '0;
      flag_vec[BIT_C]  = alu_bus.c_out;
      flag_vec[BIT_DC] = alu_bus.dc_out;
      flag_vec[BIT_Z]  = alu_bus.z_out;
   end

   assign exec_status = (ex_valid && ex_dest_status) ?
                        ((bus_status & ~result_wmask) | (alu_bus.result & result_wmask)) :
                        bus_status;
   assign flagged_status = (exec_status & ~flag_wmask) | (flag_vec & flag_wmask);

   // Device events alone move the time-out and power-down flags; time-out wins
   always_comb begin
      next_status = flagged_status;
      if (watchdog_clear_instr) begin
         next_status[BIT_TO] = 1'b1;
         next_status[BIT_PD] = 1'b1;
      end else if (sleep_instr) begin
         next_status[BIT_TO] = 1'b1;
         next_status[BIT_PD] = 1'b0;
      end
      if (watchdog_timeout_event) begin
         next_status[BIT_TO] = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status     <= STATUS_RESET;
         result_reg <= RESULT_RESET;
      end else begin
         status <= next_status;
         if (ex_valid) begin
            result_reg <= alu_bus.result;
         end
      end
   end

   assign ex_result             = result_reg;
   assign status_out            = status;
   assign indirect_bank_sel     = status[BIT_IRP];
   assign direct_bank_sel_hi    = status[BIT_RP1];
   assign direct_bank_sel_lo    = status[BIT_RP0];
   assign watchdog_timeout_flag = status[BIT_TO];
   assign power_down_flag       = status[BIT_PD];
   assign zero_flag             = status[BIT_Z];
   assign digit_carry_flag      = status[BIT_DC];
   assign carry_flag            = status[BIT_C];

   // Bank bits become the top of the nine-bit data address
   assign direct_addr   = {status[BIT_RP1], status[BIT_RP0], dir_file_addr};
   assign indirect_addr = {status[BIT_IRP], fsr};
   // Status decodes on the in-bank offset only, so every bank sees it
   assign status_selected = (dir_file_addr == STATUS_FILE_ADDR);
endmodule // cpu_status_flag_register

// file: hdl/status_reg_pkg.sv
package status_reg_pkg;
   localparam int DATA_W        = 8;
   localparam int NIBBLE_W      = 4;
   localparam int FILE_ADDR_W   = 7;
   localparam int BANK_ADDR_W   = 9;
   localparam int BIT_SEL_W     = 3;
   localparam int AXI_ADDR_W    = 4;
   localparam int AXI_DATA_W    = 32;
   localparam int AXI_STRB_W    = 4;

   localparam logic [AXI_ADDR_W-1:0] OFF_STATUS = 4'h0;
   localparam logic [AXI_ADDR_W-1:0] OFF_RESULT = 4'h4;
   localparam logic [AXI_ADDR_W-1:0] OFF_BANK   = 4'h8;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   localparam int BIT_C   = 0;
   localparam int BIT_DC  = 1;
   localparam int BIT_Z   = 2;
   localparam int BIT_PD  = 3;
   localparam int BIT_TO  = 4;
   localparam int BIT_RP0 = 5;
   localparam int BIT_RP1 = 6;
   localparam int BIT_IRP = 7;

   // Arithmetic flags have no defined reset value; zero is used here
   localparam logic [DATA_W-1:0] STATUS_RESET  = 8'h18;
   localparam logic [DATA_W-1:0] MASK_HW_ONLY  = 8'h18;
   localparam logic [DATA_W-1:0] MASK_BANK     = 8'he0;
   localparam logic [DATA_W-1:0] MASK_ARITH    = 8'h07;
   localparam logic [DATA_W-1:0] MASK_ZERO     = 8'h04;
   localparam logic [DATA_W-1:0] MASK_CARRY    = 8'h01;
   localparam logic [DATA_W-1:0] MASK_NONE     = 8'h00;
   localparam logic [DATA_W-1:0] RESULT_RESET  = 8'h00;

   localparam logic [FILE_ADDR_W-1:0] STATUS_FILE_ADDR = 7'h03;

   typedef enum logic [3:0] {
      OP_ADD  = 4'h0,
      OP_SUB  = 4'h1,
      OP_AND  = 4'h2,
      OP_IOR  = 4'h3,
      OP_XOR  = 4'h4,
      OP_COM  = 4'h5,
      OP_INC  = 4'h6,
      OP_DEC  = 4'h7,
      OP_CLR  = 4'h8,
      OP_MOVF = 4'h9,
      OP_MOVW = 4'ha,
      OP_RRF  = 4'hb,
      OP_RLF  = 4'hc,
      OP_SWAP = 4'hd,
      OP_BCF  = 4'he,
      OP_BSF  = 4'hf
   } alu_op_t;
endpackage

// file: hdl/alu_if.sv
`timescale 1ns/1ps
interface alu_if;
   import status_reg_pkg::*;
   alu_op_t                op;
   logic [DATA_W-1:0]      a;
   logic [DATA_W-1:0]      b;
   logic                   carry_in;
   logic [BIT_SEL_W-1:0]   bit_sel;
   logic [DATA_W-1:0]      result;
   logic                   c_out;
   logic                   dc_out;
   logic                   z_out;
   logic [DATA_W-1:0]      affect;

   modport core (output op, a, b, carry_in, bit_sel,
                 input  result, c_out, dc_out, z_out, affect);
   modport alu  (input  op, a, b, carry_in, bit_sel,
                 output result, c_out, dc_out, z_out, affect);
endinterface

// file: hdl/flag_alu.sv
`timescale 1ns/1ps
module flag_alu
   import status_reg_pkg::*;
(
   alu_if.alu              bus
);
   logic [DATA_W:0]        add_sum;
   logic [DATA_W:0]        sub_sum;
   logic [NIBBLE_W:0]      add_nib;
   logic [NIBBLE_W:0]      sub_nib;
   logic [DATA_W-1:0]      neg_a;
   logic [DATA_W-1:0]      one_hot_bit;

   assign add_sum = {1'b0, bus.b} + {1'b0, bus.a};
   assign add_nib = {1'b0, bus.b[NIBBLE_W-1:0]} + {1'b0, bus.a[NIBBLE_W-1:0]};
   // b minus a done as b plus the two's complement of a; no borrow leaves carry set
   assign neg_a   = ~bus.a;
   assign sub_sum = {1'b0, bus.b} + {1'b0, neg_a} + {{DATA_W{1'b0}}, 1'b1};
   assign sub_nib = {1'b0, bus.b[NIBBLE_W-1:0]} + {1'b0, neg_a[NIBBLE_W-1:0]}
                  + {{NIBBLE_W{1'b0}}, 1'b1};
   assign one_hot_bit = 8'h01 << bus.bit_sel;

   always_comb begin
      bus.result = bus.b;
      bus.c_out  = bus.carry_in;
      bus.dc_out = 1'b0;
      bus.affect = MASK_NONE;
      case (bus.op)
         OP_ADD: begin
            bus.result = add_sum[DATA_W-1:0];
            bus.c_out  = add_sum[DATA_W];
            bus.dc_out = add_nib[NIBBLE_W];
            bus.affect = MASK_ARITH;
         end
         OP_SUB: begin
            bus.result = sub_sum[DATA_W-1:0];
            bus.c_out  = sub_sum[DATA_W];
            bus.dc_out = sub_nib[NIBBLE_W];
            bus.affect = MASK_ARITH;
         end
         OP_AND: begin
            bus.result = bus.a & bus.b;
            bus.affect = MASK_ZERO;
         end
         OP_IOR: begin
            bus.result = bus.a | bus.b;
            bus.affect = MASK_ZERO;
         end
         OP_XOR: begin
            bus.result = bus.a ^ bus.b;
            bus.affect = MASK_ZERO;
         end
         OP_COM: begin
            bus.result = ~bus.b;
            bus.affect = MASK_ZERO;
         end
         OP_INC: begin
            bus.result = bus.b + 8'h01;
            bus.affect = MASK_ZERO;
         end
         OP_DEC: begin
            bus.result = bus.b - 8'h01;
            bus.affect = MASK_ZERO;
         end
         OP_CLR: begin
            bus.result = 8'h00;
            bus.affect = MASK_ZERO;
         end
         OP_MOVF: begin
            bus.result = bus.b;
            bus.affect = MASK_ZERO;
         end
         OP_MOVW: begin
            bus.result = bus.a;
         end
         OP_RRF: begin
            bus.result = {bus.carry_in, bus.b[DATA_W-1:1]};
            bus.c_out  = bus.b[0];
            bus.affect = MASK_CARRY;
         end
         OP_RLF: begin
            bus.result = {bus.b[DATA_W-2:0], bus.carry_in};
            bus.c_out  = bus.b[DATA_W-1];
            bus.affect = MASK_CARRY;
         end
         OP_SWAP: begin
            bus.result = {bus.b[NIBBLE_W-1:0], bus.b[DATA_W-1:NIBBLE_W]};
         end
         OP_BCF: begin
            bus.result = bus.b & ~one_hot_bit;
         end
         OP_BSF: begin
            bus.result = bus.b | one_hot_bit;
         end
         default: begin
            bus.result = bus.b;
         end
      endcase
      bus.z_out = (bus.result == 8'h00);
   end
endmodule // flag_alu

// file: verification/status_checker_props.sv
`timescale 1ns/1ps
module status_checker
   import status_reg_pkg::*;
(
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   input  wire logic                    ex_valid,
   input  wire alu_op_t                 ex_op,
   input  wire logic [DATA_W-1:0]       ex_result,
   input  wire logic [DATA_W-1:0]       status_out,
   input  wire logic                    watchdog_timeout_event,
   input  wire logic                    watchdog_clear_instr,
   input  wire logic                    sleep_instr,
   input  wire logic [FILE_ADDR_W-1:0]  dir_file_addr,
   input  wire logic [DATA_W-1:0]       fsr,
   input  wire logic [BANK_ADDR_W-1:0]  direct_addr,
   input  wire logic [BANK_ADDR_W-1:0]  indirect_addr,
   input  wire logic                    status_selected
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_no_event;
      !watchdog_timeout_event && !watchdog_clear_instr && !sleep_instr;
   endsequence
   sequence s_zero_op;
      ex_valid && (ex_op inside {OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR, OP_CLR});
   endsequence
   // Reset must be watched while it is active, so the default disable is overridden
   property p_reset_val; disable iff (1'b0) !aresetn |=> status_out[7:3] == 5'h03; endproperty
   a_reset_val: assert property (p_reset_val) else $error("bank or reset-cause bits wrong after reset");
   property p_timeout; watchdog_timeout_event |=> !status_out[BIT_TO]; endproperty
   a_timeout: assert property (p_timeout) else $error("time-out flag not cleared");
   property p_clear; watchdog_clear_instr && !watchdog_timeout_event |=> status_out[4:3] == 2'h3; endproperty
   a_clear: assert property (p_clear) else $error("watchdog clear did not set flags");
   property p_sleep; sleep_instr && !watchdog_clear_instr && !watchdog_timeout_event
      |=> status_out[4:3] == 2'h2; endproperty
   a_sleep: assert property (p_sleep) else $error("sleep flags wrong");
   property p_hw_only; s_no_event |=> $stable(status_out[4:3]); endproperty
   a_hw_only: assert property (p_hw_only) else $error("reset-cause flags changed without event");
   property p_direct; direct_addr == {status_out[6:5], dir_file_addr}; endproperty
   a_direct: assert property (p_direct) else $error("direct address bank wrong");
   property p_indirect; indirect_addr == {status_out[7], fsr}; endproperty
   a_indirect: assert property (p_indirect) else $error("indirect address bank wrong");
   property p_select; status_selected == (dir_file_addr == STATUS_FILE_ADDR); endproperty
   a_select: assert property (p_select) else $error("status select wrong");
   property p_zero; s_zero_op |=> status_out[BIT_Z] == (ex_result == 8'h00); endproperty
   a_zero: assert property (p_zero) else $error("zero flag disagrees with result");
endmodule // status_checker
bind cpu_status_flag_register status_checker u_chk (.*);

// file: verification/exec_unit_model.sv
`timescale 1ns/1ps
module exec_unit_model
   import status_reg_pkg::*;
(
   input  wire logic                    aclk,
   output      logic                    ex_valid,
   output      alu_op_t                 ex_op,
   output      logic [DATA_W-1:0]       ex_w,
   output      logic [DATA_W-1:0]       ex_file,
   output      logic                    ex_dest_status,
   output      logic [BIT_SEL_W-1:0]    ex_bit
);
   initial begin
      ex_valid = 1'h0;
      ex_op = OP_MOVW;
      ex_w = 8'h00;
      ex_file = 8'h00;
      ex_dest_status = 1'h0;
      ex_bit = 3'h0;
   end
   // Operands flip once the pulse ends, so a stale value is never mistaken for a live one
   task issue(input alu_op_t op, input logic [7:0] w, input logic [7:0] f, input logic d,
              input logic [2:0] b);
      @(posedge aclk);
      ex_valid <= 1'h1;
      ex_op <= op;
      ex_w <= w;
      ex_file <= f;
      ex_dest_status <= d;
      ex_bit <= b;
      @(posedge aclk);
      ex_valid <= 1'h0;
      ex_w <= ~w;
      ex_file <= ~f;
   endtask
endmodule // exec_unit_model

// file: verification/tb_cpu_status_flag_register.sv
`timescale 1ns/1ps
module tb_cpu_status_flag_register
   import status_reg_pkg::*;
;
   logic                    aclk = 1'h0, aresetn = 1'h0;
   logic [AXI_ADDR_W-1:0]   s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
   logic [AXI_DATA_W-1:0]   s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [AXI_STRB_W-1:0]   s_axi_wstrb = 4'h0;
   logic                    s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic                    s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic                    watchdog_timeout_event = 1'h0, watchdog_clear_instr = 1'h0;
   logic                    sleep_instr = 1'h0;
   logic [FILE_ADDR_W-1:0]  dir_file_addr = 7'h0;
   logic [DATA_W-1:0]       fsr = 8'h0, ex_w, ex_file, ex_result, status_out;
   logic                    s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]              s_axi_bresp, s_axi_rresp, rs;
   logic                    ex_valid, ex_dest_status, indirect_bank_sel, direct_bank_sel_hi;
   logic                    direct_bank_sel_lo, watchdog_timeout_flag, power_down_flag, zero_flag;
   logic                    digit_carry_flag, carry_flag, status_selected;
   alu_op_t                 ex_op;
   logic [BIT_SEL_W-1:0]    ex_bit;
   logic [BANK_ADDR_W-1:0]  direct_addr, indirect_addr;
   int                      err_count = 0, compares = 0;
   always #12.5 aclk = ~aclk;
   cpu_status_flag_register u_dut (.*);
   exec_unit_model u_exec (.*);
   task conclude;
      if (err_count == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task bound(input int n);
      check(32'(n < 50), 32'h1);
      if (n >= 50) conclude();
   endtask
   task axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      logic aw_hs, w_hs, b_hs;
      r = 2'h0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      // Handshakes are judged from settled values, so the edge itself decides
      for (n = 0; n < 50; n++) begin
         #1;
         aw_hs = s_axi_awvalid && s_axi_awready;
         w_hs = s_axi_wvalid && s_axi_wready;
         b_hs = s_axi_bvalid && s_axi_bready;
         if (b_hs) r = s_axi_bresp;
         @(posedge aclk);
         if (aw_hs) s_axi_awvalid <= 1'h0;
         if (w_hs) s_axi_wvalid <= 1'h0;
         if (b_hs) break;
      end
      bound(n);
      s_axi_bready <= 1'h0;
   endtask
   task axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      logic ar_hs, r_hs;
      d = 32'h0;
      r = 2'h0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      for (n = 0; n < 50; n++) begin
         #1;
         ar_hs = s_axi_arvalid && s_axi_arready;
         r_hs = s_axi_rvalid && s_axi_rready;
         if (r_hs) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
         end
         @(posedge aclk);
         if (ar_hs) s_axi_arvalid <= 1'h0;
         if (r_hs) break;
      end
      bound(n);
      s_axi_rready <= 1'h0;
   endtask
   task pulse(input logic t, input logic c, input logic s, input logic [7:0] exp);
      @(posedge aclk);
      {watchdog_timeout_event, watchdog_clear_instr, sleep_instr} <= {t, c, s};
      @(posedge aclk);
      {watchdog_timeout_event, watchdog_clear_instr, sleep_instr} <= 3'h0;
      #1 check(status_out, exp);
   endtask
   task run_ex(input alu_op_t op, input logic [7:0] w, f, input logic d, input logic [2:0] b,
               input logic [7:0] es, er);
      u_exec.issue(op, w, f, d, b);
      #1 check(status_out, es);
      check(ex_result, er);
   endtask
   task t_reset;
      @(posedge aclk);
      axi_read(OFF_STATUS, rd, rs);
      check(rd, 32'h18);
      axi_read(4'hc, rd, rs);
      check(rs, RESP_SLVERR);
   endtask
   task t_events;
      pulse(1'h0, 1'h0, 1'h1, 8'h10);
      pulse(1'h1, 1'h0, 1'h0, 8'h00);
      pulse(1'h1, 1'h1, 1'h0, 8'h08);
      pulse(1'h0, 1'h1, 1'h0, 8'h18);
      pulse(1'h0, 1'h0, 1'h1, 8'h10);
   endtask
   task t_bus;
      axi_write(OFF_STATUS, 32'hffff_ffff, rs);
      axi_read(OFF_STATUS, rd, rs);
      check(rd, 32'hf7);
      dir_file_addr <= 7'h03;
      fsr <= 8'ha5;
      @(posedge aclk);
      #1 check({direct_addr, indirect_addr, status_selected}, {9'h183, 9'h1a5, 1'h1});
      axi_write(4'hc, 32'h0, rs);
      check(rs, RESP_SLVERR);
      axi_write(OFF_STATUS, 32'he3, rs);
      #1 check(status_out, 8'hf3);
      check({indirect_bank_sel, direct_bank_sel_hi, direct_bank_sel_lo, watchdog_timeout_flag,
             power_down_flag, zero_flag, digit_carry_flag, carry_flag}, 8'hf3);
      axi_read(OFF_BANK, rd, rs);
      check(rd, 32'h103);
   endtask
   // Write masking on status as destination, clear and add first, then neutral ops
   task t_dest;
      run_ex(OP_CLR, 8'h00, 8'h00, 1'h1, 3'h0, 8'h17, 8'h00);
      run_ex(OP_ADD, 8'h0a, 8'h55, 1'h1, 3'h0, 8'h32, 8'h21);
      run_ex(OP_BCF, 8'h00, 8'h00, 1'h1, 3'h5, 8'h12, 8'h12);
      run_ex(OP_SWAP, 8'h00, 8'h00, 1'h1, 3'h0, 8'h31, 8'h21);
      run_ex(OP_MOVW, 8'h00, 8'h00, 1'h1, 3'h0, 8'h10, 8'h00);
      run_ex(OP_BSF, 8'h00, 8'h00, 1'h1, 3'h7, 8'h90, 8'h90);
      run_ex(OP_BCF, 8'h00, 8'h00, 1'h1, 3'h7, 8'h10, 8'h10);
   endtask
   task t_arith;
      run_ex(OP_ADD, 8'h0f, 8'h01, 1'h0, 3'h0, 8'h12, 8'h10);
      run_ex(OP_ADD, 8'hff, 8'h01, 1'h0, 3'h0, 8'h17, 8'h00);
      run_ex(OP_SUB, 8'h01, 8'h01, 1'h0, 3'h0, 8'h17, 8'h00);
      run_ex(OP_SUB, 8'h02, 8'h01, 1'h0, 3'h0, 8'h10, 8'hff);
      run_ex(OP_SUB, 8'h10, 8'h20, 1'h0, 3'h0, 8'h13, 8'h10);
      run_ex(OP_AND, 8'hf0, 8'h0f, 1'h0, 3'h0, 8'h17, 8'h00);
      run_ex(OP_RRF, 8'h00, 8'h02, 1'h0, 3'h0, 8'h16, 8'h81);
      run_ex(OP_RLF, 8'h00, 8'h80, 1'h0, 3'h0, 8'h17, 8'h00);
      run_ex(OP_RLF, 8'h00, 8'h01, 1'h0, 3'h0, 8'h16, 8'h03);
   endtask
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'h1;
      t_reset();
      t_events();
      t_bus();
      t_dest();
      t_arith();
      conclude();
   end
endmodule // tb_cpu_status_flag_register
